// ===== verilog/aswa_ctrl.sv
// host controller driving an asynchronous 256k x 16 static memory
// Operation
// - write happens only while write strobe and chip select are both low
// - controller drives data only after memory outputs are turned off
// - select or strobe stays high whenever the address changes
// - address valid before or with chip select falling for a read
// - wait one read cycle after retention exit before any access not yet in setup
`timescale 1ns/1ps
`include "aswa_cfg.svh"
module aswa_ctrl #(
	parameter int ADDR_W = `ASWA_ADDR_W,
	parameter int DATA_W = `ASWA_DATA_W,
	parameter int READ_CYC = `ASWA_READ_CYC,
	parameter int WRITE_CYC = `ASWA_WRITE_CYC,
	parameter int TURN_CYC = `ASWA_TURN_CYC
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// user request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_lane_en,
	output logic req_ready,
	// user answer
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	// retention exit notice
	input wire logic retention_exit,
	// memory pins
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_chip_sel_n,
	output logic mem_write_n,
	output logic mem_out_gate_n,
	output logic low_byte_lane_n,
	output logic high_byte_lane_n,
	input wire logic [DATA_W-1:0] mem_data_i,
	output logic [DATA_W-1:0] mem_data_o,
	output logic [DATA_W-1:0] mem_data_oe
);
	import aswa_pkg::*;

	logic rst_meta_q;
	logic rst_sync_n;
	aswa_state_type state_q;
	logic [`ASWA_CNT_W-1:0] cnt_q;
	logic write_q;
	logic [DATA_W-1:0] data_sync;
	logic exit_pend_q;
	logic exit_now;
	logic acc_done;
	logic [DATA_W-1:0] lane_mask;

	// access length; reads run two cycles longer so the synchronised word has settled
	assign acc_done = state_q == ASWA_ACCESS &&
		32'(cnt_q) >= (write_q ? WRITE_CYC : READ_CYC + 2);

	// an exit noticed mid-access is parked in a flag, so the hold-off is never lost
	assign exit_now = retention_exit || exit_pend_q;

	// per-bit lane mask: lower half follows the low lane, upper half the high lane
	for (genvar b = 0; b < DATA_W; b++) begin : g_lane
		assign lane_mask[b] = (b < DATA_W / 2) ? ~low_byte_lane_n : ~high_byte_lane_n;
	end

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// read data is a pin input, so it is synchronised before capture
	aswa_sync #(
		.W(DATA_W)
	) u_data_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_sync_n),
		.ce(clk_en),
		.d(mem_data_i),
		.q(data_sync)
	);

	// exit flag: set only outside idle; idle turns it into a hold-off and drops it
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			exit_pend_q <= 1'b0;
		end else if (clk_en) begin
			if (retention_exit && state_q != ASWA_IDLE) begin
				exit_pend_q <= 1'b1;
			end else if (state_q == ASWA_IDLE) begin
				exit_pend_q <= 1'b0;
			end
		end
	end

	// sequencer: address changes only in idle with select high
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_q <= ASWA_RECOVER;
			cnt_q <= '0;
			write_q <= 1'b0;
		end else if (clk_en) begin
			case (state_q)
				ASWA_IDLE: begin
					if (exit_now) begin
						state_q <= ASWA_RECOVER;
						cnt_q <= '0;
					end else if (req_valid) begin
						write_q <= req_write;
						state_q <= ASWA_SETUP;
						cnt_q <= '0;
					end
				end
				ASWA_SETUP: begin
					// address settled one cycle before select falls
					state_q <= ASWA_ACCESS;
				end
				ASWA_ACCESS: begin
					// sync adds two cycles of latency on reads
					if (32'(cnt_q) >= (write_q ? WRITE_CYC : READ_CYC + 2)) begin
						state_q <= ASWA_FINISH;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				ASWA_FINISH: begin
					// bus turnaround gap before the next access
					if (32'(cnt_q) + 1 >= TURN_CYC) begin
						state_q <= ASWA_IDLE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				ASWA_RECOVER: begin
					// hold off one read cycle after retention
					if (32'(cnt_q) + 1 >= READ_CYC) begin
						state_q <= ASWA_IDLE;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				default: begin
					state_q <= ASWA_IDLE;
					cnt_q <= '0;
				end
			endcase
		end
	end

	// address and lane latching only while select is high
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mem_addr <= '0;
			mem_data_o <= '0;
			low_byte_lane_n <= 1'b1;
			high_byte_lane_n <= 1'b1;
		end else if (clk_en && state_q == ASWA_IDLE && req_valid && !exit_now) begin
			mem_addr <= req_addr;
			mem_data_o <= req_wdata;
			low_byte_lane_n <= ~req_lane_en[0];
			high_byte_lane_n <= ~req_lane_en[1];
		end
	end

	// pin strobes; select and strobe rise together, committing the word
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mem_chip_sel_n <= 1'b1;
			mem_write_n <= 1'b1;
			mem_out_gate_n <= 1'b1;
			mem_data_oe <= '0;
		end else if (clk_en) begin
			if (state_q == ASWA_SETUP) begin
				mem_chip_sel_n <= 1'b0;
				mem_write_n <= ~write_q;
				mem_out_gate_n <= write_q;
				// drive data from the strobe falling until one cycle after it rises, memory already floating
				mem_data_oe <= write_q ? lane_mask : '0;
			end else if (acc_done) begin
				mem_chip_sel_n <= 1'b1;
				mem_write_n <= 1'b1;
				mem_out_gate_n <= 1'b1;
			end else if (state_q == ASWA_FINISH) begin
				// data held one cycle past the strobe edge for hold time
				mem_data_oe <= '0;
			end
		end
	end

	// answer: read word captured as the access ends
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			req_ready <= 1'b0;
		end else if (clk_en) begin
			rsp_valid <= acc_done;
			if (state_q == ASWA_ACCESS && !write_q) begin
				// disabled lanes read back as zero
				rsp_rdata <= data_sync & lane_mask;
			end
			// ready is only a hint; a pending exit means the next idle is a hold-off
			req_ready <= (state_q == ASWA_IDLE && !(req_valid || exit_now)) ||
				(state_q == ASWA_FINISH && 32'(cnt_q) + 1 >= TURN_CYC && !exit_now) ||
				(state_q == ASWA_RECOVER && 32'(cnt_q) + 1 >= READ_CYC && !exit_now);
		end
	end
endmodule

// ===== verilog/aswa_cfg.svh
// timing counts and field widths for the word-array memory controller
`ifndef ASWA_CFG_SVH
`define ASWA_CFG_SVH
`define ASWA_CLK_PERIOD_NS 50
`define ASWA_ADDR_W 18
`define ASWA_DATA_W 16
`define ASWA_LANES 2
`define ASWA_LANE_W 8
// slowest grade figures in ns, cycle counts derived from them (least times round up)
`define ASWA_READ_CYCLE_MIN_NS 25
`define ASWA_WRITE_PULSE_MIN_NS 17
`define ASWA_TURN_MIN_NS 8
`define ASWA_CYC_UP(ns) (((ns) + `ASWA_CLK_PERIOD_NS - 1) / `ASWA_CLK_PERIOD_NS)
`define ASWA_READ_CYC `ASWA_CYC_UP(`ASWA_READ_CYCLE_MIN_NS)
`define ASWA_WRITE_CYC `ASWA_CYC_UP(`ASWA_WRITE_PULSE_MIN_NS)
`define ASWA_TURN_CYC `ASWA_CYC_UP(`ASWA_TURN_MIN_NS)
`define ASWA_CNT_W 4
`endif

// ===== verilog/aswa_pkg.sv
// types shared by the word-array memory controller
package aswa_pkg;
	typedef enum logic [2:0] {
		ASWA_IDLE = 3'h0,
		ASWA_SETUP = 3'h1,
		ASWA_ACCESS = 3'h3,
		ASWA_FINISH = 3'h2,
		ASWA_RECOVER = 3'h6
	} aswa_state_type;
endpackage

// ===== verilog/aswa_sync.sv
// two-flop synchroniser for a pin input bus
`timescale 1ns/1ps
module aswa_sync #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	// first stage feeds only the second
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ===== dv/aswa_ctrl_sva.sv
// pin checks for the word-array memory controller
`timescale 1ns/1ps
module aswa_ctrl_sva #(parameter int ADDR_W = 18, parameter int DATA_W = 16) (
	// clock, reset and user side
	input wire logic clk_sys, rst_n, retention_exit, rsp_valid,
	// memory pins
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_chip_sel_n, mem_write_n, mem_out_gate_n,
	input wire logic low_byte_lane_n, high_byte_lane_n,
	input wire logic [DATA_W-1:0] mem_data_o, mem_data_oe
);
	logic [15:0] lanes;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// bits that the enabled lanes must carry during a write
	assign lanes = {{8{!high_byte_lane_n}}, {8{!low_byte_lane_n}}};
	addr_hold_a: assert property (!mem_chip_sel_n |=> $stable(mem_addr))
		else $error("address moved in access");
	no_fight_a: assert property (|mem_data_oe |-> mem_out_gate_n)
		else $error("drive with gate low");
	write_pair_a: assert property (!mem_write_n |-> !mem_chip_sel_n)
		else $error("strobe without select");
	read_gate_a: assert property (!mem_out_gate_n |-> !mem_chip_sel_n && mem_write_n)
		else $error("gate outside read");
	commit_hold_a: assert property (
		$rose(mem_write_n) |-> $rose(mem_chip_sel_n) && $stable(mem_data_o))
		else $error("write end broken");
	lane_drive_a: assert property (!mem_write_n |-> (mem_data_oe & lanes) == lanes)
		else $error("lane not driven");
	access_end_a: assert property (
		$fell(mem_chip_sel_n) |-> ##[1:6] $rose(mem_chip_sel_n))
		else $error("access too long");
	rsp_pulse_a: assert property ($rose(mem_chip_sel_n) |-> rsp_valid ##1 !rsp_valid)
		else $error("answer pulse wrong");
	exit_wait_a: assert property (
		retention_exit && mem_chip_sel_n |=> mem_chip_sel_n [*2])
		else $error("access too soon");
	cover property ($rose(mem_out_gate_n));
	cover property ($rose(mem_write_n));
	cover property (!mem_write_n && low_byte_lane_n);
endmodule
bind aswa_ctrl aswa_ctrl_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_sva (.clk_sys, .rst_n,
	.retention_exit, .rsp_valid, .mem_addr, .mem_chip_sel_n, .mem_write_n, .mem_out_gate_n,
	.low_byte_lane_n, .high_byte_lane_n, .mem_data_o, .mem_data_oe);

// ===== dv/aswa_mem_model.sv
// behavioural 256k x 16 static memory
`timescale 1ns/1ps
module aswa_mem_model (
	// pins
	input wire logic [17:0] addr,
	input wire logic cs_n, we_n, oe_n, low_byte_lane_n, high_byte_lane_n,
	input wire logic [15:0] d_o, d_oe,
	output logic [15:0] bus
);
	logic [15:0] mem [0:262143];
	logic [15:0] en, drv, keep;
	logic wr;
	// only a read drives, lane by lane
	assign en = {{8{!high_byte_lane_n}}, {8{!low_byte_lane_n}}} & {16{!cs_n && !oe_n && we_n}};
	assign wr = !cs_n && !we_n;
	assign drv = (d_oe & d_o) | (en & mem[addr]);
	// released bits show the inverse, so a stale value never passes
	always @* if (|(en | d_oe)) keep = drv;
	assign bus = ((en | d_oe) & drv) | (~(en | d_oe) & ~keep);
	// commit enabled bytes as the write ends
	always @(negedge wr) begin
		if (!low_byte_lane_n) mem[addr][7:0] = bus[7:0];
		if (!high_byte_lane_n) mem[addr][15:8] = bus[15:8];
	end
endmodule

// ===== dv/async_sram_word_array_test.sv
// bench for the word-array memory controller
`timescale 1ns/1ps
module async_sram_word_array_test;
	logic clk_sys = 0, rst_n = 0, clk_en = 1, req_valid = 0, req_write = 0;
	logic retention_exit = 0, req_ready, rsp_valid, mem_chip_sel_n, mem_write_n;
	logic mem_out_gate_n, low_byte_lane_n, high_byte_lane_n;
	logic [17:0] req_addr = '0, mem_addr;
	logic [15:0] req_wdata = '0, rd, rsp_rdata, mem_data_i, mem_data_o, mem_data_oe;
	logic [1:0] req_lane_en = '0;
	int errors = 0, cmp_count = 0, cyc = 0;
	aswa_ctrl i_dut (.clk_sys, .rst_n, .clk_en, .req_valid, .req_write, .req_addr, .req_wdata,
		.req_lane_en, .req_ready, .rsp_valid, .rsp_rdata, .retention_exit, .mem_addr,
		.mem_chip_sel_n, .mem_write_n, .mem_out_gate_n, .low_byte_lane_n, .high_byte_lane_n,
		.mem_data_i, .mem_data_o, .mem_data_oe);
	aswa_mem_model i_mem (.addr(mem_addr), .cs_n(mem_chip_sel_n), .we_n(mem_write_n),
		.oe_n(mem_out_gate_n), .low_byte_lane_n, .high_byte_lane_n,
		.d_o(mem_data_o), .d_oe(mem_data_oe), .bus(mem_data_i));
	initial forever #25 clk_sys = ~clk_sys;
	// ceiling far above the roughly 120 cycles needed
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic step(int n = 1);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// request held until select falls, then wait for the answer
	task automatic access(logic w, logic [17:0] a, logic [15:0] d, logic [1:0] ln);
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_lane_en = ln;
		while (mem_chip_sel_n) step();
		req_valid = 0;
		while (!rsp_valid) step();
		rd = rsp_rdata;
		step();
		chk("ready after access", {15'h0, req_ready}, 16'h1);
	endtask
	task automatic t_ends();
		access(1, 18'h3ffff, 16'hbeef, 2'h3);
		access(1, 18'h00000, 16'h1234, 2'h3);
		access(0, 18'h3ffff, 16'h0, 2'h3);
		chk("top word", rd, 16'hbeef);
		access(0, 18'h00000, 16'h0, 2'h3);
		chk("bottom word", rd, 16'h1234);
	endtask
	task automatic t_lanes();
		access(1, 18'h000a5, 16'hffff, 2'h3);
		access(1, 18'h000a5, 16'h1234, 2'h1);
		access(1, 18'h000a5, 16'habcd, 2'h2);
		access(0, 18'h000a5, 16'h0, 2'h3);
		chk("merged word", rd, 16'hab34);
		access(0, 18'h000a5, 16'h0, 2'h1);
		chk("low lane", rd, 16'h0034);
		access(0, 18'h000a5, 16'h0, 2'h2);
		chk("high lane", rd, 16'hab00);
	endtask
	task automatic t_exit();
		retention_exit = 1;
		step();
		chk("ready in hold", {15'h0, req_ready}, 16'h0);
		retention_exit = 0;
		access(0, 18'h000a5, 16'h0, 2'h3);
		chk("after exit", rd, 16'hab34);
		// an exit seen mid-access must still hold off the next access
		req_valid = 1;
		req_write = 0;
		while (mem_chip_sel_n) step();
		req_valid = 0;
		retention_exit = 1;
		step();
		retention_exit = 0;
		while (!rsp_valid) step();
		step();
		chk("ready after late exit", {15'h0, req_ready}, 16'h0);
		step();
	endtask
	// enable low for two cycles mid-read: pins hold, the word still arrives
	task automatic t_freeze();
		req_valid = 1;
		while (mem_chip_sel_n) step();
		req_valid = 0;
		clk_en = 0;
		step(2);
		chk("frozen select", {15'h0, mem_chip_sel_n}, 16'h0);
		chk("frozen answer", {15'h0, rsp_valid}, 16'h0);
		clk_en = 1;
		while (!rsp_valid) step();
		chk("read after freeze", rsp_rdata, 16'hab34);
		step();
	endtask
	// reset in mid-run: strobes idle at once, memory contents survive
	task automatic t_reset();
		rst_n = 0;
		step();
		chk("reset select", {15'h0, mem_chip_sel_n}, 16'h1);
		chk("reset ready", {15'h0, req_ready}, 16'h0);
		rst_n = 1;
		step(4);
		chk("ready after reset", {15'h0, req_ready}, 16'h1);
		access(0, 18'h3ffff, 16'h0, 2'h3);
		chk("kept word", rd, 16'hbeef);
	endtask
	task automatic print_verdict();
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		step(10);
		rst_n = 1;
		step(8);
		t_ends();
		t_lanes();
		t_exit();
		t_freeze();
		t_reset();
		print_verdict();
	end
endmodule
